// [logic/fcms_regs.vh]
// Purpose: register offsets, fields, reset values, timing counts
// Assumes: 8-bit register port, byte offsets
// Notes:   definitions only
`ifndef FCMS_REGS_VH
`define FCMS_REGS_VH

// register offsets
`define FCMS_OFF_CTRL1       8'h00
`define FCMS_OFF_CTRL2       8'h01
`define FCMS_OFF_STATUS      8'h02
`define FCMS_OFF_MODE        8'h03

// control-1 fields: clock_select[7:6], reference_divider[5:3],
// internal_ref_select[2]
`define FCMS_C1_CLKSEL_HI    7
`define FCMS_C1_CLKSEL_LO    6
`define FCMS_C1_REFDIV_HI    5
`define FCMS_C1_REFDIV_LO    3
`define FCMS_C1_INTSEL       2
`define FCMS_C1_RESET        8'h04

// control-2 fields: bus_divider[7:6], low_power_bit[3],
// ext_ref_oscillator_select[2], ext_ref_enable[1]
`define FCMS_C2_BUSDIV_HI    7
`define FCMS_C2_BUSDIV_LO    6
`define FCMS_C2_LOWPWR       3
`define FCMS_C2_OSCSEL       2
`define FCMS_C2_EXTEN        1
`define FCMS_C2_WMASK        8'hCE
`define FCMS_C2_RESET        8'h40

// clock_status_fine_trim fields
`define FCMS_SC_REFST        4
`define FCMS_SC_MODEST_HI    3
`define FCMS_SC_MODEST_LO    2
`define FCMS_SC_OSCRDY       1
`define FCMS_SC_TRIM         0
`define FCMS_SC_RESET        8'h10

// clock modes
`define FCMS_CLK_FLL         2'b00
`define FCMS_CLK_INT         2'b01
`define FCMS_CLK_EXT         2'b10

// timing: mode-switch settle count and oscillator start-up
`define FCMS_SETTLE_CYCLES   4
`define FCMS_OSC_INIT_CYCLES 4096

`endif

// [logic/fcms_sync.v]
// Purpose: two-flop synchroniser for one level
// Assumes: single clock i_clk, synchronous active-high reset
// Notes:   first stage feeds only the second
`timescale 1ns/1ps
`default_nettype none
module fcms_sync #(
  parameter RESET_VAL = 1'b0
) (
  // clock and reset
  input  wire i_clk,
  input  wire i_rst,
  // level
  input  wire i_d,
  output wire o_q
);
  reg meta_reg;
  reg sync_reg;

  always @(posedge i_clk) begin
    if (i_rst) begin
      meta_reg <= RESET_VAL;
      sync_reg <= RESET_VAL;
    end else begin
      meta_reg <= i_d;
      sync_reg <= meta_reg;
    end
  end

  assign o_q = sync_reg;
endmodule // fcms_sync
`default_nettype wire

// [logic/fcms_top.v]
// Purpose: FLL clock mode control and status register block
// Assumes: 40 MHz i_clk; clock-present pins come from other domains
// Notes:   analog loop and oscillator lie outside; this drives controls
`timescale 1ns/1ps
`default_nettype none
`include "fcms_regs.vh"
module fcms_top #(
  parameter OSC_INIT_CYCLES = `FCMS_OSC_INIT_CYCLES,
  parameter SETTLE_CYCLES   = `FCMS_SETTLE_CYCLES
) (
  // clock and reset
  input  wire       i_clk,
  input  wire       i_rst,
  // register port
  input  wire [7:0] i_addr,
  input  wire [7:0] i_wdata,
  input  wire       i_wr,
  input  wire       i_rd,
  output reg  [7:0] o_rdata,
  // clock presence and debug, from other domains
  input  wire       i_int_ref_alive,
  input  wire       i_ext_ref_alive,
  input  wire       i_debug_mode,
  // controls to the analog clock generator
  output reg  [1:0] o_out_clk_sel,
  output reg        o_fll_enable,
  output reg        o_fll_ref_internal,
  output reg  [2:0] o_reference_divider,
  output reg        o_int_ref_enable,
  output reg        o_ext_ref_enable,
  output reg        o_osc_enable,
  output reg        o_debug_link_clock_en,
  output reg        o_fine_trim_bit,
  output reg  [1:0] o_bus_divider,
  output reg  [2:0] o_mode
);
  // operating states
  localparam [2:0] ST_ENG_INT     = 3'd0;
  localparam [2:0] ST_ENG_EXT     = 3'd1;
  localparam [2:0] ST_BYP_INT     = 3'd2;
  localparam [2:0] ST_BYP_INT_LOW = 3'd3;
  localparam [2:0] ST_BYP_EXT     = 3'd4;
  localparam [2:0] ST_BYP_EXT_LOW = 3'd5;
  localparam [2:0] ST_STOP        = 3'd6;

  localparam OSC_W = 16;
  // counts are cut to the counter widths on purpose
  localparam integer OSC_LAST_I    = OSC_INIT_CYCLES - 1;
  localparam integer SETTLE_LAST_I = SETTLE_CYCLES - 1;
  localparam [OSC_W-1:0] OSC_LAST  = OSC_LAST_I[OSC_W-1:0];
  localparam [3:0] SETTLE_LAST     = SETTLE_LAST_I[3:0];

  // software controls
  reg [1:0] clock_select_reg;
  reg [2:0] reference_divider_reg;
  reg       internal_ref_select_reg;
  reg [1:0] bus_divider_reg;
  reg       low_power_bit_reg;
  reg       ext_ref_oscillator_select_reg;
  reg       ext_ref_enable_reg;
  reg       fine_trim_bit_reg;
  // status
  reg       ref_source_status_reg;
  reg [1:0] clock_mode_status_reg;
  reg       osc_ready_flag_reg;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  reg [OSC_W-1:0] osc_cnt_reg;
  reg [3:0] settle_cnt_reg;
  reg       pend_reg;

  wire int_alive;
  wire ext_alive;
  wire dbg;

  fcms_sync #(.RESET_VAL(1'b1)) u_sync_int (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (i_int_ref_alive),
    .o_q   (int_alive)
  );
  fcms_sync #(.RESET_VAL(1'b0)) u_sync_ext (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (i_ext_ref_alive),
    .o_q   (ext_alive)
  );
  fcms_sync #(.RESET_VAL(1'b0)) u_sync_dbg (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .i_d   (i_debug_mode),
    .o_q   (dbg)
  );

  wire wr_c1 = i_wr && (i_addr == `FCMS_OFF_CTRL1);
  wire wr_c2 = i_wr && (i_addr == `FCMS_OFF_CTRL2);
  wire wr_sc = i_wr && (i_addr == `FCMS_OFF_STATUS);

  // requested mode from software controls and the debug pin
  always @* begin
    state_next = state_reg;
    case (clock_select_reg)
      `FCMS_CLK_FLL: begin
        state_next = internal_ref_select_reg ?
                     ST_ENG_INT : ST_ENG_EXT;
      end
      `FCMS_CLK_INT: begin
        if (internal_ref_select_reg) begin
          if (dbg || !low_power_bit_reg)
            state_next = ST_BYP_INT;
          else
            state_next = ST_BYP_INT_LOW;
        end
      end
      `FCMS_CLK_EXT: begin
        if (!internal_ref_select_reg) begin
          if (dbg || !low_power_bit_reg)
            state_next = ST_BYP_EXT;
          else
            state_next = ST_BYP_EXT_LOW;
        end
      end
      default: state_next = state_reg;
    endcase
  end

  // the clock the requested state runs from must be present
  reg target_ok;
  always @* begin
    target_ok = 1'b0;
    case (state_next)
      ST_ENG_INT, ST_BYP_INT, ST_BYP_INT_LOW: target_ok = int_alive;
      ST_ENG_EXT, ST_BYP_EXT, ST_BYP_EXT_LOW: target_ok = ext_alive;
      default: target_ok = 1'b0;
    endcase
  end

  wire ext_used = ext_ref_enable_reg || (state_reg == ST_ENG_EXT) ||
                  (state_reg == ST_BYP_EXT) ||
                  (state_reg == ST_BYP_EXT_LOW);

  always @(posedge i_clk) begin
    if (i_rst) begin
      clock_select_reg              <= 2'b00;
      reference_divider_reg         <= 3'b000;
      internal_ref_select_reg       <= 1'b1;
      bus_divider_reg               <= 2'b01;
      low_power_bit_reg             <= 1'b0;
      ext_ref_oscillator_select_reg <= 1'b0;
      ext_ref_enable_reg            <= 1'b0;
      fine_trim_bit_reg             <= 1'b0;
    end else begin
      if (wr_c1) begin
        clock_select_reg <= i_wdata[`FCMS_C1_CLKSEL_HI:`FCMS_C1_CLKSEL_LO];
        reference_divider_reg <=
          i_wdata[`FCMS_C1_REFDIV_HI:`FCMS_C1_REFDIV_LO];
        internal_ref_select_reg <= i_wdata[`FCMS_C1_INTSEL];
      end
      if (wr_c2) begin
        bus_divider_reg <= i_wdata[`FCMS_C2_BUSDIV_HI:`FCMS_C2_BUSDIV_LO];
        low_power_bit_reg             <= i_wdata[`FCMS_C2_LOWPWR];
        ext_ref_oscillator_select_reg <= i_wdata[`FCMS_C2_OSCSEL];
        ext_ref_enable_reg            <= i_wdata[`FCMS_C2_EXTEN];
      end
      // other status bits ignore writes
      if (wr_sc)
        fine_trim_bit_reg <= i_wdata[`FCMS_SC_TRIM];
    end
  end

  // mode switch waits for settled, present new clock
  always @(posedge i_clk) begin
    if (i_rst) begin
      state_reg      <= ST_ENG_INT;
      settle_cnt_reg <= 4'h0;
      pend_reg       <= 1'b0;
    end else if (state_next == state_reg) begin
      settle_cnt_reg <= 4'h0;
      pend_reg       <= 1'b0;
    end else if (!target_ok) begin
      // missing clock: previous mode stays
      settle_cnt_reg <= 4'h0;
      pend_reg       <= 1'b1;
    end else if (settle_cnt_reg == SETTLE_LAST) begin
      state_reg      <= state_next;
      settle_cnt_reg <= 4'h0;
      pend_reg       <= 1'b0;
    end else begin
      settle_cnt_reg <= settle_cnt_reg + 4'h1;
      pend_reg       <= 1'b1;
    end
  end

  // status follows the state, so it lags the select write
  always @(posedge i_clk) begin
    if (i_rst) begin
      ref_source_status_reg <= 1'b1;
      clock_mode_status_reg <= `FCMS_CLK_FLL;
    end else begin
      case (state_reg)
        ST_ENG_INT: begin
          ref_source_status_reg <= 1'b1;
          clock_mode_status_reg <= `FCMS_CLK_FLL;
        end
        ST_ENG_EXT: begin
          ref_source_status_reg <= 1'b0;
          clock_mode_status_reg <= `FCMS_CLK_FLL;
        end
        ST_BYP_INT, ST_BYP_INT_LOW: begin
          ref_source_status_reg <= 1'b1;
          clock_mode_status_reg <= `FCMS_CLK_INT;
        end
        ST_BYP_EXT, ST_BYP_EXT_LOW: begin
          ref_source_status_reg <= 1'b0;
          clock_mode_status_reg <= `FCMS_CLK_EXT;
        end
        default: begin
          ref_source_status_reg <= ref_source_status_reg;
          clock_mode_status_reg <= clock_mode_status_reg;
        end
      endcase
    end
  end

  // oscillator start-up count and ready flag
  always @(posedge i_clk) begin
    if (i_rst) begin
      osc_cnt_reg        <= {OSC_W{1'b0}};
      osc_ready_flag_reg <= 1'b0;
    end else if (!ext_ref_enable_reg && !ext_used ||
                 !ext_ref_oscillator_select_reg) begin
      osc_cnt_reg <= {OSC_W{1'b0}};
      // every counter clear also drops the flag
      if (!ext_ref_enable_reg || !ext_ref_oscillator_select_reg)
        osc_ready_flag_reg <= 1'b0;
    end else if (!osc_ready_flag_reg && ext_alive) begin
      if (osc_cnt_reg == OSC_LAST)
        osc_ready_flag_reg <= 1'b1;
      else
        osc_cnt_reg <= osc_cnt_reg + {{(OSC_W-1){1'b0}}, 1'b1};
    end
  end

  // analog controls decoded from the settled state and the control registers
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_out_clk_sel         <= `FCMS_CLK_FLL;
      o_fll_enable          <= 1'b1;
      o_fll_ref_internal    <= 1'b1;
      o_reference_divider   <= 3'b000;
      o_int_ref_enable      <= 1'b1;
      o_ext_ref_enable      <= 1'b0;
      o_osc_enable          <= 1'b0;
      o_debug_link_clock_en <= 1'b1;
      o_fine_trim_bit       <= 1'b0;
      o_bus_divider         <= 2'b01;
      o_mode                <= ST_ENG_INT;
    end else begin
      o_mode              <= state_reg;
      o_reference_divider <= reference_divider_reg;
      o_bus_divider       <= bus_divider_reg;
      // set lengthens int ref period one step, clear shortens
      o_fine_trim_bit     <= fine_trim_bit_reg;
      o_osc_enable        <= ext_ref_oscillator_select_reg && ext_used;
      case (state_reg)
        ST_ENG_INT, ST_BYP_INT: begin
          o_out_clk_sel <= (state_reg == ST_ENG_INT) ?
                           `FCMS_CLK_FLL : `FCMS_CLK_INT;
          o_fll_enable          <= 1'b1;
          o_fll_ref_internal    <= 1'b1;
          o_int_ref_enable      <= 1'b1;
          o_ext_ref_enable      <= ext_ref_enable_reg;
          o_debug_link_clock_en <= 1'b1;
        end
        ST_BYP_INT_LOW: begin
          o_out_clk_sel         <= `FCMS_CLK_INT;
          o_fll_enable          <= 1'b0;
          o_fll_ref_internal    <= 1'b1;
          o_int_ref_enable      <= 1'b1;
          o_ext_ref_enable      <= ext_ref_enable_reg;
          o_debug_link_clock_en <= 1'b0;
        end
        ST_ENG_EXT, ST_BYP_EXT: begin
          o_out_clk_sel <= (state_reg == ST_ENG_EXT) ?
                           `FCMS_CLK_FLL : `FCMS_CLK_EXT;
          o_fll_enable          <= 1'b1;
          o_fll_ref_internal    <= 1'b0;
          o_int_ref_enable      <= 1'b0;
          o_ext_ref_enable      <= 1'b1;
          o_debug_link_clock_en <= 1'b1;
        end
        ST_BYP_EXT_LOW: begin
          o_out_clk_sel         <= `FCMS_CLK_EXT;
          o_fll_enable          <= 1'b0;
          o_fll_ref_internal    <= 1'b0;
          o_int_ref_enable      <= 1'b0;
          o_ext_ref_enable      <= 1'b1;
          o_debug_link_clock_en <= 1'b0;
        end
        default: begin
          o_out_clk_sel         <= o_out_clk_sel;
          o_fll_enable          <= o_fll_enable;
          o_fll_ref_internal    <= o_fll_ref_internal;
          o_int_ref_enable      <= o_int_ref_enable;
          o_ext_ref_enable      <= o_ext_ref_enable;
          o_debug_link_clock_en <= o_debug_link_clock_en;
        end
      endcase
    end
  end

  // read data valid only in the cycle after the strobe
  always @(posedge i_clk) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `FCMS_OFF_CTRL1:
          o_rdata <= {clock_select_reg, reference_divider_reg,
                      internal_ref_select_reg, 2'b00};
        `FCMS_OFF_CTRL2:
          o_rdata <= {bus_divider_reg, 2'b00, low_power_bit_reg,
                      ext_ref_oscillator_select_reg,
                      ext_ref_enable_reg, 1'b0};
        `FCMS_OFF_STATUS:
          o_rdata <= {3'b000, ref_source_status_reg,
                      clock_mode_status_reg, osc_ready_flag_reg,
                      fine_trim_bit_reg};
        `FCMS_OFF_MODE:
          o_rdata <= {3'b000, pend_reg, 1'b0, state_reg};
        default:
          o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end
endmodule // fcms_top
`default_nettype wire

// [test/fcms_top_monitor.sv]
// Purpose: port-level assertions for fcms_top
// Assumes: one clock, synchronous active-high reset
// Notes:   mode checks wait one cycle because outputs lag the state
`timescale 1ns/1ps
`default_nettype none
module fcms_top_monitor #(
  parameter OSC_INIT_CYCLES = 8,
  parameter SETTLE_CYCLES   = 4
) (
  // clock, reset and register port
  input wire logic       i_clk,
  input wire logic       i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // generator controls
  input wire logic [1:0] o_out_clk_sel,
  input wire logic       o_fll_enable,
  input wire logic       o_fll_ref_internal,
  input wire logic       o_int_ref_enable,
  input wire logic       o_ext_ref_enable,
  input wire logic       o_debug_link_clock_en,
  input wire logic       o_fine_trim_bit,
  input wire logic [1:0] o_bus_divider,
  input wire logic [2:0] o_mode
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  sequence s_ctl_wr;
    i_wr && (i_addr == 8'h00 || i_addr == 8'h01);
  endsequence
  sequence s_mode_hold;
    $stable(o_mode) [*3];
  endsequence

  property p_status_mirror;
    i_rd && i_addr == 8'h02 |=> o_rdata[7:5] == 3'b000 &&
      o_rdata[3:2] == $past(o_out_clk_sel) &&
      o_rdata[4] == $past(o_fll_ref_internal);
  endproperty
  a_status_mirror: assert property (p_status_mirror)
    else $error("status read does not mirror mode outputs");

  property p_mode_legal;
    o_mode <= 3'd5 && o_out_clk_sel != 2'b11;
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("undefined mode or clock source");

  property p_eng_int;
    $stable(o_mode) && o_mode == 3'd0 |-> o_out_clk_sel == 2'b00 &&
      o_fll_enable && o_debug_link_clock_en && o_int_ref_enable &&
      o_fll_ref_internal;
  endproperty
  a_eng_int: assert property (p_eng_int)
    else $error("engaged internal outputs wrong");

  property p_eng_ext;
    $stable(o_mode) && o_mode == 3'd1 |-> o_out_clk_sel == 2'b00 &&
      o_fll_enable && o_debug_link_clock_en && o_ext_ref_enable &&
      !o_fll_ref_internal;
  endproperty
  a_eng_ext: assert property (p_eng_ext)
    else $error("engaged external outputs wrong");

  property p_byp_int;
    $stable(o_mode) && o_mode == 3'd2 |-> o_out_clk_sel == 2'b01 &&
      o_fll_enable && o_debug_link_clock_en && o_int_ref_enable;
  endproperty
  a_byp_int: assert property (p_byp_int)
    else $error("bypassed internal outputs wrong");

  property p_byp_int_low;
    $stable(o_mode) && o_mode == 3'd3 |-> o_out_clk_sel == 2'b01 &&
      !o_fll_enable && !o_debug_link_clock_en && o_int_ref_enable;
  endproperty
  a_byp_int_low: assert property (p_byp_int_low)
    else $error("bypassed internal low power outputs wrong");

  property p_byp_ext;
    $stable(o_mode) && o_mode == 3'd4 |-> o_out_clk_sel == 2'b10 &&
      o_fll_enable && o_debug_link_clock_en && o_ext_ref_enable;
  endproperty
  a_byp_ext: assert property (p_byp_ext)
    else $error("bypassed external outputs wrong");

  property p_byp_ext_low;
    $stable(o_mode) && o_mode == 3'd5 |-> o_out_clk_sel == 2'b10 &&
      !o_fll_enable && o_ext_ref_enable;
  endproperty
  a_byp_ext_low: assert property (p_byp_ext_low)
    else $error("bypassed external low power outputs wrong");

  property p_trim_wr;
    i_wr && i_addr == 8'h02 |-> ##2 o_fine_trim_bit == $past(i_wdata[0], 2);
  endproperty
  a_trim_wr: assert property (p_trim_wr)
    else $error("fine trim did not follow write");

  // o_mode must hold for three cycles after a control write
  property p_settle;
    s_ctl_wr |=> s_mode_hold;
  endproperty
  a_settle: assert property (p_settle)
    else $error("mode changed too soon after control write");

  property p_reset_default;
    disable iff (1'b0) $fell(i_rst) |-> o_mode == 3'd0 &&
      o_bus_divider == 2'b01 && o_out_clk_sel == 2'b00;
  endproperty
  a_reset_default: assert property (p_reset_default)
    else $error("reset defaults wrong");
endmodule // fcms_top_monitor

bind fcms_top fcms_top_monitor #(
  .OSC_INIT_CYCLES(OSC_INIT_CYCLES), .SETTLE_CYCLES(SETTLE_CYCLES)
) u_mon (
  .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
  .o_out_clk_sel(o_out_clk_sel), .o_fll_enable(o_fll_enable),
  .o_fll_ref_internal(o_fll_ref_internal),
  .o_int_ref_enable(o_int_ref_enable), .o_ext_ref_enable(o_ext_ref_enable),
  .o_debug_link_clock_en(o_debug_link_clock_en),
  .o_fine_trim_bit(o_fine_trim_bit), .o_bus_divider(o_bus_divider),
  .o_mode(o_mode)
);
`default_nettype wire

// [test/fcms_top_test.sv]
// Purpose: register and mode-switch tests for fcms_top
// Assumes: 40 MHz clock, short oscillator start-up count
// Notes:   each mode step waits well past sync plus settle time
`timescale 1ns/1ps
`default_nettype none
module fcms_top_test;
  logic       i_clk = 1'b0;
  logic       i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_int_ref_alive = 1'b1;
  logic       i_ext_ref_alive = 1'b1;
  logic       i_debug_mode = 1'b0;
  wire  [7:0] o_rdata;
  wire  [1:0] o_out_clk_sel;
  wire  [1:0] o_bus_divider;
  wire  [2:0] o_mode;
  wire  [2:0] o_reference_divider;
  wire        o_fll_enable;
  wire        o_fll_ref_internal;
  wire        o_int_ref_enable;
  wire        o_ext_ref_enable;
  wire        o_osc_enable;
  wire        o_debug_link_clock_en;
  wire        o_fine_trim_bit;
  int         error_cnt = 0;
  int         compares = 0;
  logic [7:0] d;

  always #12.5 i_clk = ~i_clk;

  fcms_top #(.OSC_INIT_CYCLES(8), .SETTLE_CYCLES(4)) i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_int_ref_alive(i_int_ref_alive), .i_ext_ref_alive(i_ext_ref_alive),
    .i_debug_mode(i_debug_mode), .o_out_clk_sel(o_out_clk_sel),
    .o_fll_enable(o_fll_enable), .o_fll_ref_internal(o_fll_ref_internal),
    .o_reference_divider(o_reference_divider),
    .o_int_ref_enable(o_int_ref_enable), .o_ext_ref_enable(o_ext_ref_enable),
    .o_osc_enable(o_osc_enable),
    .o_debug_link_clock_en(o_debug_link_clock_en),
    .o_fine_trim_bit(o_fine_trim_bit), .o_bus_divider(o_bus_divider),
    .o_mode(o_mode));

  task automatic report_and_stop;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= v;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    #1;
    v = o_rdata;
  endtask

  task automatic step(input logic [7:0] c1, input logic [7:0] c2,
                      input logic dbg, input logic ext,
                      input logic [2:0] md, input logic [2:0] st);
    @(posedge i_clk);
    i_debug_mode    <= dbg;
    i_ext_ref_alive <= ext;
    wr(8'h01, c2);
    wr(8'h00, c1);
    repeat (20) @(posedge i_clk);
    #1;
    chk({5'd0, o_mode}, {5'd0, md});
    rd(8'h02, d);
    chk({5'd0, d[4:2]}, {5'd0, st});
  endtask

  initial begin
    #200_000;
    error_cnt++;
    report_and_stop;
  end

  initial begin
    repeat (3) @(posedge i_clk);
    i_rst <= 1'b0;
    rd(8'h00, d); chk(d, 8'h04);
    rd(8'h01, d); chk(d, 8'h40);
    rd(8'h02, d); chk(d, 8'h10);
    wr(8'h02, 8'hFF);
    rd(8'h02, d); chk(d, 8'h11);
    chk({7'd0, o_fine_trim_bit}, 8'h01);
    wr(8'h02, 8'h00);
    rd(8'h02, d); chk(d, 8'h10);
    wr(8'h20, 8'hFF);
    rd(8'h20, d); chk(d, 8'h00);
    rd(8'h00, d); chk(d, 8'h04);
    for (int k = 0; k < 4; k++) begin
      wr(8'h01, {k[1:0], 6'd0});
      repeat (3) @(posedge i_clk);
      #1;
      chk({6'd0, o_bus_divider}, {6'd0, k[1:0]});
    end
    step(8'h44, 8'h40, 1'b0, 1'b1, 3'd2, 3'b101);
    step(8'h44, 8'h48, 1'b0, 1'b1, 3'd3, 3'b101);
    step(8'h44, 8'h48, 1'b1, 1'b1, 3'd2, 3'b101);
    step(8'h80, 8'h40, 1'b0, 1'b1, 3'd4, 3'b010);
    step(8'h80, 8'h48, 1'b0, 1'b1, 3'd5, 3'b010);
    step(8'h40, 8'h48, 1'b0, 1'b1, 3'd5, 3'b010);
    step(8'hC0, 8'h48, 1'b0, 1'b1, 3'd5, 3'b010);
    step(8'h0C, 8'h40, 1'b0, 1'b1, 3'd0, 3'b100);
    chk({5'd0, o_reference_divider}, 8'h01);
    step(8'h00, 8'h40, 1'b0, 1'b0, 3'd0, 3'b100);
    rd(8'h03, d);
    chk(d, 8'h10);
    step(8'h00, 8'h40, 1'b0, 1'b1, 3'd1, 3'b000);
    chk({7'd0, d[1]}, 8'h00);
    step(8'h00, 8'h44, 1'b0, 1'b1, 3'd1, 3'b000);
    chk({7'd0, o_osc_enable}, 8'h01);
    repeat (10) @(posedge i_clk);
    rd(8'h02, d); chk({7'd0, d[1]}, 8'h01);
    step(8'h04, 8'h46, 1'b0, 1'b1, 3'd0, 3'b100);
    chk({7'd0, d[1]}, 8'h01);
    step(8'h04, 8'h44, 1'b0, 1'b1, 3'd0, 3'b100);
    chk({7'd0, d[1]}, 8'h00);
    chk({7'd0, o_osc_enable}, 8'h00);
    report_and_stop;
  end
endmodule // fcms_top_test
`default_nettype wire
